// file: core/clock_gen_pkg.sv
// constants, field layout and mode type of the clock generator control block
`default_nettype none
package clock_gen_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_CTRL_ONE   = 8'h00;
    localparam logic [7:0] OFS_CTRL_TWO   = 8'h04;
    localparam logic [7:0] OFS_STATUS     = 8'h08;
    localparam logic [7:0] OFS_TRIM       = 8'h0C;
    // clock_control_one fields
    localparam int CS_HI       = 7;
    localparam int CS_LO       = 6;
    localparam int REF_DIVIDER_HI     = 5;
    localparam int REF_DIVIDER_LO     = 3;
    localparam int IREF_BIT    = 2;
    localparam int PLL_BIT     = 1;
    // clock_control_two fields
    localparam int BUS_DIVIDER_HI     = 7;
    localparam int BUS_DIVIDER_LO     = 6;
    localparam int RANGE_BIT   = 5;
    localparam int HGO_BIT     = 4;
    localparam int LPB_BIT     = 3;
    localparam int EXT_REF_SELECT_BIT   = 2;
    localparam int EXT_REF_OUTPUT_ENABLE_BIT = 1;
    localparam int STOPKEEP_BIT = 0;
    // status fields
    localparam int IREFST_BIT  = 4;
    localparam int CLKST_HI    = 3;
    localparam int CLKST_LO    = 2;
    localparam int OSCRDY_BIT  = 1;
    localparam int FINE_TRIM_BIT_BIT   = 0;
    // reset values
    localparam logic [7:0] CTRL_ONE_RST = 8'h04;
    localparam logic [7:0] CTRL_TWO_RST = 8'h40;
    localparam logic [7:0] TRIM_RST     = 8'h80;
    // clock_source_select and divider codes
    localparam logic [1:0] CS_LOOP      = 2'h0;
    localparam logic [1:0] CS_INTERNAL  = 2'h1;
    localparam logic [1:0] CS_EXTERNAL  = 2'h2;
    localparam logic [1:0] BUS_DIVIDER_BY1     = 2'h0;
    localparam logic [1:0] BUS_DIVIDER_BY2     = 2'h1;
    localparam logic [2:0] REF_DIVIDER_MIN_BY1 = 3'h2;
    localparam logic [2:0] REF_DIVIDER_MIN_BY2 = 3'h3;
    // timing
    localparam int CLK_MHZ          = 250;
    localparam int IREF_STABLE_NS   = 1000;
    localparam int STABLE_W         = 16;
    typedef enum {
        internal_ref_fll_engaged, ext_ref_fll_engaged, ext_bypass_fll, internal_bypass_fll,
        internal_bypass_low_power, ext_bypass_low_power, ext_bypass_pll, ext_ref_pll_engaged
    } gen_mode_e;
endpackage
`default_nettype wire

// file: core/clock_generator_control.sv
// clock generator control: registers, mode tracking, dividers and clock enables
//
// Design decisions made here: register access over APB and the register offsets.
`default_nettype none
module clock_generator_control #(
    parameter int iref_stable_ns = clock_gen_pkg::IREF_STABLE_NS
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output var  logic [31:0] prdata,
    output var  logic        pready,
    output var  logic        pslverr,
    input  wire logic        osc_init_pin,
    input  wire logic        stop_mode,
    output var  logic        bus_clk_en,
    output var  logic        fixed_freq_clock,
    output var  logic        fixed_freq_valid,
    output var  logic        ext_ref_clock_out,
    output var  logic        ext_ref_running,
    output var  logic        loop_off,
    output var  logic        fll_acquire,
    output var  logic        osc_high_range,
    output var  logic        osc_high_gain,
    output var  logic        osc_crystal_sel,
    output var  logic [7:0]  trim_value,
    output var  logic        fine_trim
);
    import clock_gen_pkg::*;

    localparam int STABLE_CYC_RAW = (iref_stable_ns * CLK_MHZ + 999) / 1000;
    localparam int STABLE_CYC     = (STABLE_CYC_RAW < 1) ? 1 : STABLE_CYC_RAW;
    localparam logic [STABLE_W-1:0] STABLE_LAST = STABLE_W'(STABLE_CYC - 1);

    typedef struct packed {
        logic [7:0]          ctrl_one;
        logic [7:0]          ctrl_two;
        logic [7:0]          trim;
        logic                fine_trim_bit;
        gen_mode_e           mode;
        logic                osc_s1;
        logic                osc_s2;
        logic [STABLE_W-1:0] stable_cnt;
        logic                stable;
        logic [2:0]          bus_cnt;
        logic                bus_en;
        logic [6:0]          ff_cnt;
        logic                ff_clk;
        logic                ff_valid;
        logic                erc_out;
        logic                erc_run;
        logic                loop_off;
        logic [31:0]         rdata;
        logic                ready;
        logic                err;
    } state_s;

    state_s state_r;
    state_s state_nxt;

    // mode that a clock_control_one value and low_power_bypass ask for
    function automatic gen_mode_e decode_mode(input logic [7:0] c1, input logic lp);
        gen_mode_e m;
        m = internal_ref_fll_engaged;
        case (c1[CS_HI:CS_LO])
            CS_LOOP: begin
                if (c1[IREF_BIT])
                    m = internal_ref_fll_engaged;
                else if (c1[PLL_BIT])
                    m = ext_ref_pll_engaged;
                else
                    m = ext_ref_fll_engaged;
            end
            CS_INTERNAL: m = lp ? internal_bypass_low_power : internal_bypass_fll;
            CS_EXTERNAL: begin
                if (lp)
                    m = ext_bypass_low_power;
                else
                    m = c1[PLL_BIT] ? ext_bypass_pll : ext_bypass_fll;
            end
            default: m = internal_ref_fll_engaged;
        endcase
        return m;
    endfunction

    // bypass modes: the output is taken straight from a reference
    function automatic logic is_bypass(input gen_mode_e m);
        return (m == ext_bypass_fll) || (m == internal_bypass_fll) || (m == ext_bypass_pll) ||
               (m == internal_bypass_low_power) || (m == ext_bypass_low_power);
    endfunction

    // modes in which the external reference feeds the generator
    function automatic logic uses_ext(input gen_mode_e m);
        return (m == ext_ref_fll_engaged) || (m == ext_bypass_fll) || (m == ext_ref_pll_engaged) ||
               (m == ext_bypass_pll) || (m == ext_bypass_low_power);
    endfunction

    // status word as software sees it
    function automatic logic [7:0] status_word(input state_s s);
        logic [7:0] w;
        w = 8'h00;
        w[IREFST_BIT]        = !uses_ext(s.mode);
        w[CLKST_HI:CLKST_LO] = s.ctrl_one[CS_HI:CS_LO];
        w[OSCRDY_BIT]        = s.osc_s2 && s.ctrl_two[EXT_REF_SELECT_BIT];
        w[FINE_TRIM_BIT_BIT]         = s.fine_trim_bit;
        return w;
    endfunction

    logic       setup_ph;
    logic       wr_go;
    logic       mapped;
    gen_mode_e  req_mode;
    logic [7:0] next_one;
    logic [7:0] next_two;
    logic [2:0] bus_mask;
    logic [6:0] ff_mask;
    logic       ff_ok;
    logic       keep_in_stop;

    always_comb begin
        state_nxt = state_r;
        setup_ph  = psel && !penable;
        wr_go     = psel && penable && state_r.ready && pwrite && !state_r.err;
        mapped    = (paddr == OFS_CTRL_ONE) || (paddr == OFS_CTRL_TWO) ||
                    (paddr == OFS_STATUS) || (paddr == OFS_TRIM);
        next_one  = state_r.ctrl_one;
        next_two  = state_r.ctrl_two;

        // zero wait states: ready in the access phase, error flags an unmapped address
        if (setup_ph) begin
            state_nxt.ready = 1'b1;
            state_nxt.err   = !mapped;
            case (paddr)
                OFS_CTRL_ONE: state_nxt.rdata = {24'h000000, state_r.ctrl_one};
                OFS_CTRL_TWO: state_nxt.rdata = {24'h000000, state_r.ctrl_two};
                OFS_STATUS:   state_nxt.rdata = {24'h000000, status_word(state_r)};
                OFS_TRIM:     state_nxt.rdata = {24'h000000, state_r.trim};
                default:      state_nxt.rdata = 32'h00000000;
            endcase
        end else if (psel && penable) begin
            state_nxt.ready = 1'b0;
            state_nxt.err   = 1'b0;
        end

        // register writes; trim only changes when software copies it in
        if (wr_go) begin
            case (paddr)
                OFS_CTRL_ONE: next_one = pwdata[7:0];
                OFS_CTRL_TWO: next_two = pwdata[7:0];
                OFS_STATUS:   state_nxt.fine_trim_bit = pwdata[FINE_TRIM_BIT_BIT];
                OFS_TRIM:     state_nxt.trim = pwdata[7:0];
                default:      next_one = state_r.ctrl_one;
            endcase
        end
        state_nxt.ctrl_one = next_one;
        state_nxt.ctrl_two = next_two;

        // reset mode may leave only for three modes; other requests leave the mode as is
        req_mode = decode_mode(next_one, next_two[LPB_BIT]);
        if (state_r.mode == internal_ref_fll_engaged) begin
            if ((req_mode == ext_ref_fll_engaged) || (req_mode == ext_bypass_fll) ||
                (req_mode == internal_bypass_fll) || (req_mode == internal_ref_fll_engaged))
                state_nxt.mode = req_mode;
        end else begin
            state_nxt.mode = req_mode;
        end

        // oscillator ready pin crosses in through two flops
        state_nxt.osc_s1 = osc_init_pin;
        state_nxt.osc_s2 = state_r.osc_s1;

        // hold lock acquisition until the internal reference has settled
        if (!state_r.stable) begin
            if (state_r.stable_cnt == STABLE_LAST)
                state_nxt.stable = 1'b1;
            else
                state_nxt.stable_cnt = state_r.stable_cnt + STABLE_W'(1);
        end

        // bus clock enable: one pulse every 1, 2, 4 or 8 cycles
        bus_mask = 3'((4'h1 << state_r.ctrl_two[BUS_DIVIDER_HI:BUS_DIVIDER_LO]) - 4'h1);
        state_nxt.bus_en = ((state_r.bus_cnt & bus_mask) == bus_mask);
        state_nxt.bus_cnt = state_r.bus_cnt + 3'h1; // free running: a reset here would stretch each period by one

        // fixed clock period of 2^ref_divider cycles, so code 111 divides by 128; code 000 stops at divide-by-2
        ff_mask = 7'((8'h01 << state_r.ctrl_one[REF_DIVIDER_HI:REF_DIVIDER_LO]) - 8'h01) >> 1;
        if ((state_r.ff_cnt & ff_mask) == ff_mask) begin
            state_nxt.ff_cnt = 7'h00;
            state_nxt.ff_clk = !state_r.ff_clk;
        end else begin
            state_nxt.ff_cnt = state_r.ff_cnt + 7'h01;
        end

        // validity recomputed every cycle from live fields, so it never goes stale
        ff_ok = 1'b1;
        if (is_bypass(state_r.mode)) begin
            if ((state_r.ctrl_two[BUS_DIVIDER_HI:BUS_DIVIDER_LO] == BUS_DIVIDER_BY1) &&
                (state_r.ctrl_one[REF_DIVIDER_HI:REF_DIVIDER_LO] < REF_DIVIDER_MIN_BY1))
                ff_ok = 1'b0;
            if ((state_r.ctrl_two[BUS_DIVIDER_HI:BUS_DIVIDER_LO] == BUS_DIVIDER_BY2) &&
                (state_r.ctrl_one[REF_DIVIDER_HI:REF_DIVIDER_LO] < REF_DIVIDER_MIN_BY2))
                ff_ok = 1'b0;
        end
        state_nxt.ff_valid = ff_ok;

        // external reference gating, including what survives stop mode
        keep_in_stop = state_r.ctrl_two[STOPKEEP_BIT] &&
                       (state_r.ctrl_two[EXT_REF_OUTPUT_ENABLE_BIT] || uses_ext(state_r.mode));
        state_nxt.erc_run = stop_mode ? keep_in_stop
                                      : (state_r.ctrl_two[EXT_REF_OUTPUT_ENABLE_BIT] || uses_ext(state_r.mode));
        state_nxt.erc_out = state_r.ctrl_two[EXT_REF_OUTPUT_ENABLE_BIT] &&
                            !(stop_mode && !state_r.ctrl_two[STOPKEEP_BIT]);

        // loop switched off in bypass when low power is asked for
        state_nxt.loop_off = state_r.ctrl_two[LPB_BIT] && is_bypass(state_r.mode);
    end

    // single state register; reset lands in the internal reference loop mode
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r            <= '0;
            state_r.ctrl_one   <= CTRL_ONE_RST;
            state_r.ctrl_two   <= CTRL_TWO_RST;
            state_r.trim       <= TRIM_RST;
            state_r.mode       <= internal_ref_fll_engaged;
        end else begin
            state_r <= state_nxt;
        end
    end

    // outputs straight from the state register
    assign prdata            = state_r.rdata;
    assign pready            = state_r.ready;
    assign pslverr           = state_r.err;
    assign bus_clk_en        = state_r.bus_en;
    assign fixed_freq_clock  = state_r.ff_clk;
    assign fixed_freq_valid  = state_r.ff_valid;
    assign ext_ref_clock_out = state_r.erc_out;
    assign ext_ref_running   = state_r.erc_run;
    assign loop_off          = state_r.loop_off;
    assign fll_acquire       = state_r.stable;
    assign osc_high_range    = state_r.ctrl_two[RANGE_BIT];
    assign osc_high_gain     = state_r.ctrl_two[HGO_BIT];
    assign osc_crystal_sel   = state_r.ctrl_two[EXT_REF_SELECT_BIT];
    assign trim_value        = state_r.trim;
    assign fine_trim         = state_r.fine_trim_bit;

    // checks
    chk_reset_divider: assert property (@(posedge pclk) $rose(presetn) |->
        state_r.ctrl_two[BUS_DIVIDER_HI:BUS_DIVIDER_LO] == BUS_DIVIDER_BY2 && state_r.mode == internal_ref_fll_engaged)
        else $error("reset did not give divide-by-2 loop mode");

    chk_bus_pulse_gap: assert property (@(posedge pclk) disable iff (!presetn)
        bus_clk_en && state_r.ctrl_two[BUS_DIVIDER_HI:BUS_DIVIDER_LO] == 2'h3 |=>
        (!bus_clk_en || state_r.ctrl_two[BUS_DIVIDER_HI:BUS_DIVIDER_LO] != 2'h3) [*7] ##1
        (bus_clk_en || state_r.ctrl_two[BUS_DIVIDER_HI:BUS_DIVIDER_LO] != 2'h3))
        else $error("bus enable too frequent for divide-by-8");

    chk_ctrl_two_wr: assert property (@(posedge pclk) disable iff (!presetn)
        psel && penable && pready && pwrite && !pslverr && paddr == OFS_CTRL_TWO
        |=> state_r.ctrl_two == $past(pwdata[7:0]))
        else $error("control two write not stored");

    chk_reset_exits: assert property (@(posedge pclk) disable iff (!presetn)
        $past(state_r.mode) == internal_ref_fll_engaged |->
        state_r.mode inside {internal_ref_fll_engaged, ext_ref_fll_engaged, ext_bypass_fll,
                             internal_bypass_fll})
        else $error("illegal direct exit from reset mode");

    chk_ff_invalid: assert property (@(posedge pclk) disable iff (!presetn)
        is_bypass(state_r.mode) && state_r.ctrl_two[BUS_DIVIDER_HI:BUS_DIVIDER_LO] == BUS_DIVIDER_BY2 &&
        state_r.ctrl_one[REF_DIVIDER_HI:REF_DIVIDER_LO] < REF_DIVIDER_MIN_BY2 |=> !fixed_freq_valid)
        else $error("fixed clock flagged valid at too high a rate");

    chk_ff_valid_fll: assert property (@(posedge pclk) disable iff (!presetn)
        !is_bypass(state_r.mode) |=> fixed_freq_valid)
        else $error("fixed clock flagged invalid outside bypass");

    chk_erc_follow: assert property (@(posedge pclk) disable iff (!presetn)
        !stop_mode |=> ext_ref_clock_out == $past(state_r.ctrl_two[EXT_REF_OUTPUT_ENABLE_BIT]))
        else $error("reference output not following its enable");

    chk_stop_drop: assert property (@(posedge pclk) disable iff (!presetn)
        stop_mode && !state_r.ctrl_two[STOPKEEP_BIT] |=> !ext_ref_running && !ext_ref_clock_out)
        else $error("reference kept in stop without stop keep");

    chk_loop_off: assert property (@(posedge pclk) disable iff (!presetn)
        state_r.ctrl_two[LPB_BIT] && is_bypass(state_r.mode) ##1 $stable(state_r.mode) |-> loop_off)
        else $error("loop not switched off in low power bypass");

    chk_lock_wait: assert property (@(posedge pclk) disable iff (!presetn)
        fll_acquire |-> $past(state_r.stable_cnt) == STABLE_LAST || $past(fll_acquire))
        else $error("lock acquisition before reference settled");

    chk_iref_status: assert property (@(posedge pclk) disable iff (!presetn)
        setup_ph && paddr == OFS_STATUS && uses_ext(state_r.mode) |=> !prdata[IREFST_BIT])
        else $error("internal reference status set while external feeds");

    chk_bus_by1: assert property (@(posedge pclk) disable iff (!presetn)
        state_r.ctrl_two[BUS_DIVIDER_HI:BUS_DIVIDER_LO] == BUS_DIVIDER_BY1 |=> bus_clk_en)
        else $error("bus enable missing at divide-by-1");

    chk_ff_invalid_by1: assert property (@(posedge pclk) disable iff (!presetn)
        is_bypass(state_r.mode) && state_r.ctrl_two[BUS_DIVIDER_HI:BUS_DIVIDER_LO] == BUS_DIVIDER_BY1 &&
        state_r.ctrl_one[REF_DIVIDER_HI:REF_DIVIDER_LO] < REF_DIVIDER_MIN_BY1 |=> !fixed_freq_valid)
        else $error("fixed clock flagged valid at divide-by-1");

    chk_stop_keep_on: assert property (@(posedge pclk) disable iff (!presetn)
        stop_mode && state_r.ctrl_two[STOPKEEP_BIT] &&
        (state_r.ctrl_two[EXT_REF_OUTPUT_ENABLE_BIT] || uses_ext(state_r.mode)) |=> ext_ref_running)
        else $error("reference dropped in stop although kept");

    chk_trim_hold: assert property (@(posedge pclk) disable iff (!presetn)
        !(psel && penable && pready && pwrite && paddr == OFS_TRIM) |=> $stable(trim_value))
        else $error("trim value changed without a software write");

    chk_lock_holdoff: assert property (@(posedge pclk) disable iff (!presetn)
        !state_r.stable && state_r.stable_cnt != STABLE_LAST |=> !fll_acquire)
        else $error("lock acquisition started early");
endmodule
`default_nettype wire

// file: testbench/crystal_osc_model.sv
// external crystal model: reports startup done a while after it is requested
`default_nettype none
module crystal_osc_model #(
    parameter int start_cyc = 20
) (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic crystal_sel,
    output var  logic init_done
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt;
    // startup restarts whenever the crystal is no longer requested
    always @(posedge pclk or negedge presetn) begin
        if (!presetn || !crystal_sel) begin
            cnt       <= 0;
            init_done <= 1'b0;
        end else if (cnt < start_cyc) begin
            cnt <= cnt + 1;
        end else begin
            init_done <= 1'b1;
        end
    end
endmodule
`default_nettype wire

// file: testbench/clock_generator_control_tb.sv
// self-checking bench for the clock generator control block
`default_nettype none
module clock_generator_control_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import clock_gen_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, stop_mode, osc_pin;
    logic [7:0]  paddr, trim;
    logic [31:0] pwdata, prdata, rd;
    logic        pready, pslverr, er, bus_clk_en, ffclk, ffvalid, erclk, erun;
    logic        loop_off, fll_acq, hrange, hgain, xsel, fine_trim_bit;
    int          fails, n_tests;

    // small settle time keeps the run short
    clock_generator_control #(.iref_stable_ns(40)) clock_generator_control_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .osc_init_pin(osc_pin), .stop_mode(stop_mode), .bus_clk_en(bus_clk_en),
        .fixed_freq_clock(ffclk), .fixed_freq_valid(ffvalid), .ext_ref_clock_out(erclk),
        .ext_ref_running(erun), .loop_off(loop_off), .fll_acquire(fll_acq),
        .osc_high_range(hrange), .osc_high_gain(hgain), .osc_crystal_sel(xsel),
        .trim_value(trim), .fine_trim(fine_trim_bit));
    crystal_osc_model #(.start_cyc(20)) crystal_osc_model_inst (
        .pclk(pclk), .presetn(presetn), .crystal_sel(xsel), .init_done(osc_pin));

    task automatic print_verdict();
        $display("checks %0d, mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask
    // one apb transfer, entered at a rising edge; ends with an idle cycle
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        // no wait limit here: only the watchdog ends a stuck transfer
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1);
        chk(pready, 1);
        chk(n, 1); // zero wait states
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask

    task automatic t_reset();
        @(posedge pclk);
        chk(fll_acq, 0);
        cyc(15);
        chk(fll_acq, 1);
        rdchk(OFS_CTRL_TWO, 32'h40);
        rdchk(OFS_CTRL_ONE, CTRL_ONE_RST);
        rdchk(OFS_STATUS, 32'h10);
    endtask
    task automatic t_trim();
        apb(1'b1, OFS_TRIM, 32'h5A);
        rdchk(OFS_TRIM, 32'h5A);
        chk(trim, 8'h5A);
        apb(1'b1, OFS_STATUS, 32'hFF);
        chk(fine_trim_bit, 1);
        rdchk(OFS_STATUS, 32'h11);
    endtask
    // unmapped access, a mode not reachable from reset, bypass-only loop gating
    task automatic t_refuse();
        apb(1'b1, 8'h10, 32'hFF);
        chk(er, 1);
        rdchk(8'h10, 32'h0);
        chk(er, 1);
        apb(1'b1, OFS_CTRL_ONE, 32'h02);
        rdchk(OFS_STATUS, 32'h11);
        rdchk(OFS_CTRL_ONE, 32'h02);
        apb(1'b1, OFS_CTRL_ONE, 32'h04);
        apb(1'b1, OFS_CTRL_TWO, 32'h48);
        cyc(2);
        chk(loop_off, 0);
    endtask
    // pulses over 32 cycles, still in the internal reference loop mode so divide-by-1 is allowed
    task automatic t_bus_divider();
        int c;
        for (int b = 0; b < 4; b++) begin
            apb(1'b1, OFS_CTRL_TWO, {24'h0, b[1:0], 6'h0});
            cyc(8);
            c = 0;
            repeat (32) begin
                @(posedge pclk);
                if (bus_clk_en === 1'b1) c++;
            end
            chk(c, 32 >> b);
            if (b == 0) chk(ffvalid, 1);
        end
        apb(1'b1, OFS_CTRL_TWO, 32'h40);
    endtask
    task automatic t_fbe();
        int k;
        apb(1'b1, OFS_CTRL_TWO, 32'h76);
        cyc(2);
        chk({hrange, hgain, xsel, erclk}, 4'hF);
        k = 0;
        do begin
            apb(1'b0, OFS_STATUS, 32'h0);
            k++;
        end while (rd[OSCRDY_BIT] !== 1'b1 && k < 60);
        chk(rd[OSCRDY_BIT], 1);
        apb(1'b1, OFS_CTRL_ONE, 32'hB8);
        rdchk(OFS_STATUS, 32'h0B);
        apb(1'b1, OFS_CTRL_TWO, 32'h7E);
        cyc(2);
        chk(loop_off, 1);
        apb(1'b1, OFS_CTRL_TWO, 32'h76);
        cyc(2);
        chk(loop_off, 0);
    endtask
    // validity table in bypass, then fixed clock half period
    task automatic t_ffv();
        logic [1:0] bd[5] = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h2};
        logic [2:0] rv[5] = '{3'h1, 3'h2, 3'h2, 3'h3, 3'h0};
        logic       ev[5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1};
        logic       p;
        int         k;
        for (int i = 0; i < 5; i++) begin
            apb(1'b1, OFS_CTRL_ONE, {24'h0, 2'h2, rv[i], 3'h0});
            apb(1'b1, OFS_CTRL_TWO, {24'h0, bd[i], 6'h36});
            cyc(2);
            chk(ffvalid, ev[i]);
        end
        apb(1'b1, OFS_CTRL_ONE, 32'hB8);
        for (int j = 0; j < 2; j++) begin
            p = ffclk;
            k = 0;
            do begin
                @(posedge pclk);
                k++;
            end while (ffclk === p && k < 200);
        end
        chk(k, 64); // half of divide-by-128
    endtask
    task automatic t_stop();
        apb(1'b1, OFS_CTRL_TWO, 32'h46);
        stop_mode <= 1'b1;
        cyc(2);
        chk({hrange, hgain, erclk, erun}, 4'h0);
        stop_mode <= 1'b0;
        apb(1'b1, OFS_CTRL_TWO, 32'h47);
        stop_mode <= 1'b1;
        cyc(2);
        chk({erclk, erun}, 2'h3);
        apb(1'b1, OFS_CTRL_TWO, 32'h45);
        cyc(2);
        chk({erclk, erun}, 2'h1);
        stop_mode <= 1'b0;
    endtask

    // clock at 250 MHz
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    // a hang counts as a mismatch
    initial begin
        cyc(20000);
        fails++;
        print_verdict();
    end
    // main sequence
    initial begin
        {presetn, psel, penable, pwrite, stop_mode} = '0;
        paddr = '0;
        pwdata = '0;
        fails = 0;
        n_tests = 0;
        cyc(2);
        presetn <= 1'b1;
        t_reset();
        t_trim();
        t_refuse();
        t_bus_divider();
        t_fbe();
        t_ffv();
        t_stop();
        print_verdict();
    end
endmodule
`default_nettype wire
